// ### logic/adc_control_status_registers.sv
// Behaviour
// - Converter clock is peripheral clock divided by 2..16 step 2, then 20..64.
// - Software sets timebase cycles per 1 us; device times guard delays with it.
// - Reference code picks supply, external, or one of four internal references.
// - Switching to an internal reference holds off conversions for 60 us.
// - Window source bit picks result (0) or latest sample (1), low 16 bits.
// - Window mode: off, below low, above high, strictly inside, or outside.
// - Six enable bits gate the interrupt of the flag at the same position.
// - Writing one clears a flag; writing zero leaves it alone.
// - Start trigger during a running conversion sets trigger overrun.
// - New sample over an unread sample sets sample overwrite.
// - New result over an unread result sets result overwrite.
// - On completion, a window condition match sets window match.
// - Sample ready sets on new sample; cleared by write one or sample read.
// - Result ready sets on new result; cleared by write one or result read.
// - Busy bit high during conversion or pending settling, low when both finish.
// - Converter enable bit gates all converter operation.
`timescale 1ns/1ps
module adc_control_status_registers (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conversion_running,
  input wire logic conversion_done,
  input wire logic result_write,
  input wire logic sample_write,
  input wire logic start_trigger,
  input wire logic result_read,
  input wire logic sample_read,
  input wire logic [15:0] result_value,
  input wire logic [15:0] sample_value,
  input wire logic [15:0] window_low_threshold,
  input wire logic [15:0] window_high_threshold,
  output logic converter_enable,
  output logic converter_clk,
  output logic [2:0] reference_choice,
  output logic reference_ready,
  output logic timebase_tick,
  output logic converter_busy,
  output logic irq
);

  logic enable_reg;
  logic [3:0] clock_divider_code;
  logic [4:0] timebase_reg;
  logic [2:0] reference_reg;
  logic window_source_select;
  logic [2:0] window_compare_mode;
  logic [5:0] int_enable_reg;
  logic [5:0] int_flags_reg;
  logic [5:0] int_flags_next;
  logic [5:0] flag_set;
  logic [5:0] flag_clear;
  logic [6:0] settle_cnt_reg;
  logic [4:0] tb_cnt_reg;
  logic tick_reg;
  logic [4:0] div_cnt_reg;
  logic [5:0] div_half;
  logic clk_div_reg;
  logic result_unread_reg;
  logic sample_unread_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  logic [31:0] read_value;
  logic addr_ok;
  logic access;
  logic wr;
  logic [5:0] idx;
  logic [15:0] window_operand;
  logic window_hit;
  logic settle_pending;

  // Bus: one wait state so that read data comes from a flop
  assign idx = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (idx <= adc_ctrl_pkg::IDX_STATUS);
  assign access = psel && penable && ack_reg;
  assign wr = access && pwrite && addr_ok;
  assign pready = access;
  assign pslverr = access && !addr_ok;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
    end
  end

  always_comb begin
    read_value = 32'h0000_0000;
    if (!addr_ok) begin
      read_value = 32'h0000_0000;
    end else if (idx == adc_ctrl_pkg::IDX_ENABLE) begin
      read_value[adc_ctrl_pkg::ENABLE_BIT] = enable_reg;
    end else if (idx == adc_ctrl_pkg::IDX_PRESCALER) begin
      read_value[adc_ctrl_pkg::CLOCK_DIVIDER_CODE_LSB +: 4] = clock_divider_code;
    end else if (idx == adc_ctrl_pkg::IDX_TIMEBASE_REF) begin
      read_value[adc_ctrl_pkg::TIMEBASE_LSB +: 5] = timebase_reg;
      read_value[adc_ctrl_pkg::REF_LSB +: 3] = reference_reg;
    end else if (idx == adc_ctrl_pkg::IDX_WINDOW) begin
      read_value[adc_ctrl_pkg::WINDOW_SOURCE_SELECT_BIT] = window_source_select;
      read_value[adc_ctrl_pkg::WINMODE_LSB +: 3] = window_compare_mode;
    end else if (idx == adc_ctrl_pkg::IDX_INT_ENABLE) begin
      read_value[5:0] = int_enable_reg;
    end else if (idx == adc_ctrl_pkg::IDX_INT_FLAGS) begin
      read_value[5:0] = int_flags_reg;
    end else begin
      read_value[adc_ctrl_pkg::BUSY_BIT] = converter_busy;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !ack_reg && !pwrite) begin
      prdata_reg <= read_value;
    end
  end

  // Configuration registers; undefined bits are simply not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= adc_ctrl_pkg::REG_RESET[0];
      clock_divider_code <= adc_ctrl_pkg::REG_RESET[3:0];
      timebase_reg <= adc_ctrl_pkg::REG_RESET[7:3];
      reference_reg <= adc_ctrl_pkg::REG_RESET[2:0];
      window_source_select <= adc_ctrl_pkg::REG_RESET[3];
      window_compare_mode <= adc_ctrl_pkg::REG_RESET[2:0];
      int_enable_reg <= adc_ctrl_pkg::REG_RESET[5:0];
    end else if (wr) begin
      if (idx == adc_ctrl_pkg::IDX_ENABLE) begin
        enable_reg <= pwdata[adc_ctrl_pkg::ENABLE_BIT];
      end else if (idx == adc_ctrl_pkg::IDX_PRESCALER) begin
        clock_divider_code <= pwdata[adc_ctrl_pkg::CLOCK_DIVIDER_CODE_LSB +: 4];
      end else if (idx == adc_ctrl_pkg::IDX_TIMEBASE_REF) begin
        timebase_reg <= pwdata[adc_ctrl_pkg::TIMEBASE_LSB +: 5];
        reference_reg <= pwdata[adc_ctrl_pkg::REF_LSB +: 3];
      end else if (idx == adc_ctrl_pkg::IDX_WINDOW) begin
        window_source_select <= pwdata[adc_ctrl_pkg::WINDOW_SOURCE_SELECT_BIT];
        window_compare_mode <= pwdata[adc_ctrl_pkg::WINMODE_LSB +: 3];
      end else if (idx == adc_ctrl_pkg::IDX_INT_ENABLE) begin
        int_enable_reg <= pwdata[5:0];
      end
    end
  end

  assign converter_enable = enable_reg;
  // Reserved reference codes are passed on unchanged; the analog side treats them as supply
  assign reference_choice = reference_reg;

  // Converter clock divider; half period in peripheral cycles
  // The top four codes step the half period by four, so it reaches 32 and needs six bits
  always_comb begin
    if (!clock_divider_code[3]) begin
      div_half = 6'({3'b000, clock_divider_code[2:0]} + 6'd1);
    end else if (!clock_divider_code[2]) begin
      div_half = 6'(({4'b0000, clock_divider_code[1:0]} + 6'd5) << 1);
    end else begin
      div_half = 6'(({4'b0000, clock_divider_code[1:0]} + 6'd5) << 2);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 5'h00;
      clk_div_reg <= 1'b0;
    end else if (!enable_reg) begin
      div_cnt_reg <= 5'h00;
      clk_div_reg <= 1'b0;
    end else if ({1'b0, div_cnt_reg} + 6'd1 >= div_half) begin
      div_cnt_reg <= 5'h00;
      clk_div_reg <= !clk_div_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'd1;
    end
  end

  assign converter_clk = clk_div_reg;

  // Timebase: one tick every max(timebase,1) peripheral cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else if (!enable_reg || tb_cnt_reg + 5'd1 >= timebase_reg) begin
      tb_cnt_reg <= 5'h00;
      tick_reg <= enable_reg;
    end else begin
      tb_cnt_reg <= tb_cnt_reg + 5'd1;
      tick_reg <= 1'b0;
    end
  end

  assign timebase_tick = tick_reg;

  // Reference start-up; a write that leaves the reference unchanged does not restart it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_reg <= 7'h00;
    end else if (wr && idx == adc_ctrl_pkg::IDX_TIMEBASE_REF &&
                 pwdata[adc_ctrl_pkg::REF_LSB +: 3] != reference_reg) begin
      if (pwdata[adc_ctrl_pkg::REF_LSB + 2]) begin
        settle_cnt_reg <= adc_ctrl_pkg::REF_INIT_TICKS;
      end else begin
        settle_cnt_reg <= 7'h00;
      end
    end else if (tick_reg && settle_cnt_reg != 7'h00) begin
      settle_cnt_reg <= settle_cnt_reg - 7'd1;
    end
  end

  assign settle_pending = (settle_cnt_reg != 7'h00);
  assign reference_ready = !settle_pending;
  assign converter_busy = enable_reg && (conversion_running || settle_pending);

  // Window comparator
  assign window_operand = window_source_select ? sample_value : result_value;

  always_comb begin
    case (window_compare_mode)
      adc_ctrl_pkg::WIN_BELOW: window_hit = window_operand < window_low_threshold;
      adc_ctrl_pkg::WIN_ABOVE: window_hit = window_operand > window_high_threshold;
      adc_ctrl_pkg::WIN_INSIDE: window_hit = (window_operand > window_low_threshold) &&
                                            (window_operand < window_high_threshold);
      adc_ctrl_pkg::WIN_OUTSIDE: window_hit = (window_operand < window_low_threshold) ||
                                             (window_operand > window_high_threshold);
      default: window_hit = 1'b0;
    endcase
  end

  // Unread tracking for overwrite detection; a write in the same cycle as a read counts as unread
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_unread_reg <= 1'b0;
      sample_unread_reg <= 1'b0;
    end else begin
      result_unread_reg <= (enable_reg && result_write) || (result_unread_reg && !result_read);
      sample_unread_reg <= (enable_reg && sample_write) || (sample_unread_reg && !sample_read);
    end
  end

  // Flag events, all gated by the converter enable
  always_comb begin
    flag_set = 6'h00;
    flag_set[adc_ctrl_pkg::FLAG_TRIG_OVR] = enable_reg && start_trigger && conversion_running;
    flag_set[adc_ctrl_pkg::FLAG_SAMP_OVR] = enable_reg && sample_write && sample_unread_reg;
    flag_set[adc_ctrl_pkg::FLAG_RES_OVR] = enable_reg && result_write && result_unread_reg;
    flag_set[adc_ctrl_pkg::FLAG_WMATCH] = enable_reg && conversion_done && window_hit;
    flag_set[adc_ctrl_pkg::FLAG_SAMP_RDY] = enable_reg && sample_write;
    flag_set[adc_ctrl_pkg::FLAG_RES_RDY] = enable_reg && result_write;
  end

  always_comb begin
    flag_clear = 6'h00;
    if (wr && idx == adc_ctrl_pkg::IDX_INT_FLAGS) begin
      flag_clear = pwdata[5:0];
    end
    flag_clear[adc_ctrl_pkg::FLAG_SAMP_RDY] = flag_clear[adc_ctrl_pkg::FLAG_SAMP_RDY] || sample_read;
    flag_clear[adc_ctrl_pkg::FLAG_RES_RDY] = flag_clear[adc_ctrl_pkg::FLAG_RES_RDY] || result_read;
  end

  // Set beats clear so an event in the clearing cycle is never lost
  for (genvar i = 0; i < adc_ctrl_pkg::NUM_FLAGS; i++) begin : g_flag
    assign int_flags_next[i] = flag_set[i] || (int_flags_reg[i] && !flag_clear[i]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flags_reg <= adc_ctrl_pkg::REG_RESET[5:0];
    end else begin
      int_flags_reg <= int_flags_next;
    end
  end

  assign irq = |(int_flags_reg & int_enable_reg);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_irq_gating: assert property (
    (int_flags_reg & int_enable_reg) == 6'h00 |-> !irq)
    else $error("interrupt output disagrees with flags and enables");

  chk_trig_overrun: assert property (
    enable_reg && start_trigger && conversion_running |=> int_flags_reg[adc_ctrl_pkg::FLAG_TRIG_OVR])
    else $error("trigger overrun flag not set");

  chk_w1c_clear: assert property (
    wr && idx == adc_ctrl_pkg::IDX_INT_FLAGS && pwdata[adc_ctrl_pkg::FLAG_WMATCH] &&
    !flag_set[adc_ctrl_pkg::FLAG_WMATCH] |=> !int_flags_reg[adc_ctrl_pkg::FLAG_WMATCH])
    else $error("write one did not clear window flag");

  chk_w0_keep: assert property (
    wr && idx == adc_ctrl_pkg::IDX_INT_FLAGS && !pwdata[adc_ctrl_pkg::FLAG_TRIG_OVR] &&
    int_flags_reg[adc_ctrl_pkg::FLAG_TRIG_OVR] |=> int_flags_reg[adc_ctrl_pkg::FLAG_TRIG_OVR])
    else $error("write zero disturbed a flag");

  chk_result_ovr: assert property (
    enable_reg && result_write && result_unread_reg
    |=> int_flags_reg[adc_ctrl_pkg::FLAG_RES_OVR] && int_flags_reg[adc_ctrl_pkg::FLAG_RES_RDY])
    else $error("result written over unread result did not flag overwrite");

  chk_sample_read: assert property (
    sample_read && !(enable_reg && sample_write) |=> !int_flags_reg[adc_ctrl_pkg::FLAG_SAMP_RDY])
    else $error("sample read did not clear sample ready");

  chk_settle_load: assert property (
    $rose(settle_pending) |-> settle_cnt_reg == adc_ctrl_pkg::REF_INIT_TICKS && reference_choice[2])
    else $error("reference start-up not loaded with full count");

  chk_busy_settle: assert property (
    enable_reg && settle_pending |-> converter_busy && !reference_ready)
    else $error("busy low while reference settles");

  chk_div_two: assert property (
    (enable_reg && clock_divider_code == 4'h0 && $past(enable_reg) &&
     $past(clock_divider_code) == 4'h0 && $past(enable_reg, 2)) |-> $changed(converter_clk))
    else $error("divide by two clock did not toggle");

  chk_window_below: assert property (
    enable_reg && conversion_done && window_compare_mode == adc_ctrl_pkg::WIN_BELOW &&
    !window_source_select && result_value < window_low_threshold
    |=> int_flags_reg[adc_ctrl_pkg::FLAG_WMATCH])
    else $error("window below match not flagged");

  chk_bad_addr: assert property (
    psel && penable && ack_reg && paddr[1:0] != 2'h0 |-> pslverr && pready)
    else $error("unaligned access not refused");

  chk_sample_ovr: assert property (
    enable_reg && sample_write && sample_unread_reg |=> int_flags_reg[adc_ctrl_pkg::FLAG_SAMP_OVR])
    else $error("unread sample overwritten without flag");

  chk_result_read: assert property (
    result_read && !(enable_reg && result_write) |=> !int_flags_reg[adc_ctrl_pkg::FLAG_RES_RDY])
    else $error("result read did not clear result ready");

  chk_disabled_quiet: assert property (
    !enable_reg |=> (int_flags_reg & ~$past(int_flags_reg)) == 6'h00 && !converter_clk && !timebase_tick)
    else $error("disabled converter raised a flag or ran a clock");

  chk_tick_spacing: assert property (
    timebase_tick && timebase_reg > 5'h01 |=> !timebase_tick)
    else $error("timebase ticks closer than the programmed count");

  chk_window_source: assert property (
    enable_reg && conversion_done && window_compare_mode == adc_ctrl_pkg::WIN_BELOW &&
    window_source_select && sample_value < window_low_threshold
    |=> int_flags_reg[adc_ctrl_pkg::FLAG_WMATCH])
    else $error("sample source window match not flagged");

  chk_reserved_mode: assert property (
    window_compare_mode > adc_ctrl_pkg::WIN_OUTSIDE |-> !flag_set[adc_ctrl_pkg::FLAG_WMATCH])
    else $error("reserved window mode produced a match");

  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  cov_overrun: cover property (int_flags_reg[adc_ctrl_pkg::FLAG_TRIG_OVR] && irq);
  cov_settle_done: cover property ($fell(settle_pending));
  cov_window_inside: cover property (flag_set[adc_ctrl_pkg::FLAG_WMATCH] &&
                                     window_compare_mode == adc_ctrl_pkg::WIN_INSIDE);
  cov_set_and_clear: cover property (flag_set[0] && flag_clear[0]);
  cov_sample_overwrite: cover property (flag_set[adc_ctrl_pkg::FLAG_SAMP_OVR]);

endmodule

// ### logic/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_ENABLE = 6'h00;
  localparam logic [5:0] IDX_PRESCALER = 6'h01;
  localparam logic [5:0] IDX_TIMEBASE_REF = 6'h02;
  localparam logic [5:0] IDX_WINDOW = 6'h03;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h04;
  localparam logic [5:0] IDX_INT_FLAGS = 6'h05;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  // Field positions
  localparam int ENABLE_BIT = 0;
  localparam int CLOCK_DIVIDER_CODE_LSB = 0;
  localparam int REF_LSB = 0;
  localparam int TIMEBASE_LSB = 3;
  localparam int WINMODE_LSB = 0;
  localparam int WINDOW_SOURCE_SELECT_BIT = 3;
  localparam int BUSY_BIT = 0;
  localparam int FLAG_TRIG_OVR = 5;
  localparam int FLAG_SAMP_OVR = 4;
  localparam int FLAG_RES_OVR = 3;
  localparam int FLAG_WMATCH = 2;
  localparam int FLAG_SAMP_RDY = 1;
  localparam int FLAG_RES_RDY = 0;
  localparam int NUM_FLAGS = 6;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Reference codes
  localparam logic [2:0] REF_SUPPLY = 3'h0;
  localparam logic [2:0] REF_EXTERNAL = 3'h2;
  localparam logic [2:0] REF_INT_1V024 = 3'h4;
  localparam logic [2:0] REF_INT_2V048 = 3'h5;
  localparam logic [2:0] REF_INT_2V500 = 3'h6;
  localparam logic [2:0] REF_INT_4V096 = 3'h7;
  // Window compare modes
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;
  // Timing: one timebase period spans at least this time
  localparam int TIMEBASE_PERIOD_US = 1;
  localparam int REF_INIT_TIME_US = 60;
  localparam logic [6:0] REF_INIT_TICKS = 7'(REF_INIT_TIME_US / TIMEBASE_PERIOD_US);
endpackage

// ### sim/tb_adc_control_status_registers.sv
`timescale 1ns/1ps
module tb_adc_control_status_registers;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic conversion_running, conversion_done, result_write, sample_write, start_trigger, result_read, sample_read;
  logic [15:0] result_value, sample_value, window_low_threshold, window_high_threshold;
  logic converter_enable, converter_clk, reference_ready, timebase_tick, converter_busy, irq;
  logic [2:0] reference_choice;
  int err_total, n_checks, p, i, n;
  int dv[16] = '{2, 4, 6, 8, 10, 12, 14, 16, 20, 24, 28, 32, 40, 48, 56, 64};
  logic [31:0] msk[5] = '{32'h01, 32'h0f, 32'hff, 32'h0f, 32'h3f};
  // Window register, result, sample, expected match
  logic [39:0] wt[14] = '{40'h0_0032_0000_0, 40'h1_0032_0000_1, 40'h1_0064_0000_0, 40'h2_00c9_0000_1,
    40'h2_00c8_0000_0, 40'h3_0096_0000_1, 40'h3_0064_0000_0, 40'h3_00c8_0000_0, 40'h4_0063_0000_1,
    40'h4_00c9_0000_1, 40'h4_0096_0000_0, 40'h9_0096_0032_1, 40'h9_0032_0096_0, 40'h5_0000_0000_0};

  adc_control_status_registers dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conversion_running, .conversion_done, .result_write, .sample_write, .start_trigger,
    .result_read, .sample_read, .result_value, .sample_value, .window_low_threshold, .window_high_threshold,
    .converter_enable, .converter_clk, .reference_choice, .reference_ready, .timebase_tick, .converter_busy,
    .irq);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task hang;
    err_total++;
    results();
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // pready is read right after the edge, before the design's updates, so it is the value that edge sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
      hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [5:0] x, input logic [31:0] d);
    apb(1'b1, {x, 2'b00}, d);
  endtask

  task rd(input logic [5:0] x, input logic [31:0] exp);
    apb(1'b0, {x, 2'b00}, 32'h0);
    check($sformatf("register %0d", x), q, exp);
  endtask

  task ev(input logic [5:0] m);
    @(posedge pclk);
    {conversion_done, start_trigger, sample_write, result_write, sample_read, result_read} <= m;
    @(posedge pclk);
    {conversion_done, start_trigger, sample_write, result_write, sample_read, result_read} <= 6'h00;
    @(posedge pclk);
  endtask

  function automatic logic pick(int s);
    return s != 0 ? timebase_tick : converter_clk;
  endfunction

  // Skips the first rise so a period cut short by the register write is not measured
  task gap(input int s, output int g);
    int k, r, a;
    logic l;
    l = pick(s);
    r = 0;
    a = 0;
    g = 0;
    for (k = 0; k < 600 && r < 3; k++) begin
      @(negedge pclk);
      if (pick(s) && !l) begin
        r++;
        if (r == 2)
          a = k;
        if (r == 3)
          g = k - a;
      end
      l = pick(s);
    end
    if (r < 3)
      hang();
  endtask

  initial begin
    err_total = 0;
    n_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {conversion_running, conversion_done, result_write, sample_write, start_trigger, result_read} = '0;
    {sample_read, result_value, sample_value} = '0;
    window_low_threshold = 16'h0064;
    window_high_threshold = 16'h00c8;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++)
      rd(i[5:0], 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    apb(1'b0, 8'h05, 32'h0);
    check("unaligned error", {31'h0, e}, 32'h1);
    for (i = 0; i < 5; i++) begin
      wr(i[5:0], 32'hffffffff);
      rd(i[5:0], msk[i]);
    end
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h0);
    wr(adc_ctrl_pkg::IDX_STATUS, 32'hff);
    rd(adc_ctrl_pkg::IDX_STATUS, 32'h0);
    for (i = 0; i < 16; i++) begin
      wr(adc_ctrl_pkg::IDX_PRESCALER, i);
      gap(0, p);
      check("divider period", p, dv[i]);
    end
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h28);
    gap(1, p);
    check("tick period 5", p, 32'd5);
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'hf8);
    gap(1, p);
    check("tick period 31", p, 32'd31);
    for (i = 0; i < 8; i++) begin
      wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h10 | i);
      @(negedge pclk);
      check("reference output", {29'h0, reference_choice}, i);
    end
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h10);
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h14);
    // Sixty ticks of two cycles; one tick of slack for the tick phase at the write
    for (n = 0; n < 400; n++) begin
      @(negedge pclk);
      if (reference_ready === 1'b1)
        break;
    end
    check("settle window", {31'h0, n >= 118 && n <= 122}, 32'h1);
    rd(adc_ctrl_pkg::IDX_STATUS, 32'h0);
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h15);
    rd(adc_ctrl_pkg::IDX_STATUS, 32'h1);
    wr(adc_ctrl_pkg::IDX_TIMEBASE_REF, 32'h12);
    rd(adc_ctrl_pkg::IDX_STATUS, 32'h0);
    conversion_running <= 1'b1;
    rd(adc_ctrl_pkg::IDX_STATUS, 32'h1);
    check("busy output", {31'h0, converter_busy}, 32'h1);
    wr(adc_ctrl_pkg::IDX_ENABLE, 32'h0);
    rd(adc_ctrl_pkg::IDX_STATUS, 32'h0);
    check("enable output", {31'h0, converter_enable}, 32'h0);
    check("clock stopped", {31'h0, converter_clk}, 32'h0);
    wr(adc_ctrl_pkg::IDX_ENABLE, 32'h1);
    ev(6'h10);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h20);
    check("irq raised", {31'h0, irq}, 32'h1);
    conversion_running <= 1'b0;
    wr(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h0);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h20);
    wr(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h20);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h0);
    ev(6'h10);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h0);
    ev(6'h08);
    ev(6'h08);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h12);
    ev(6'h02);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h10);
    wr(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h10);
    ev(6'h08);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h02);
    ev(6'h04);
    ev(6'h04);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h0b);
    ev(6'h01);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h0a);
    wr(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h02);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h08);
    for (i = 0; i < 6; i++) begin
      wr(adc_ctrl_pkg::IDX_INT_ENABLE, 32'h1 << i);
      @(negedge pclk);
      check("irq gate", {31'h0, irq}, {31'h0, i == 3});
    end
    wr(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h3f);
    wr(adc_ctrl_pkg::IDX_ENABLE, 32'h0);
    ev(6'h3f);
    rd(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h0);
    wr(adc_ctrl_pkg::IDX_ENABLE, 32'h1);
    for (i = 0; i < 14; i++) begin
      wr(adc_ctrl_pkg::IDX_WINDOW, {28'h0, wt[i][39:36]});
      result_value <= wt[i][35:20];
      sample_value <= wt[i][19:4];
      ev(6'h20);
      rd(adc_ctrl_pkg::IDX_INT_FLAGS, {29'h0, wt[i][0], 2'b00});
      wr(adc_ctrl_pkg::IDX_INT_FLAGS, 32'h3f);
    end
    results();
  end
endmodule
